// [move_decode_pkg.sv]
// Package: opcodes, field layout and carrier structs for the move group decoder
package move_decode_pkg;

   localparam int INSTR_W = 14;
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 7;
   localparam int DIR_BIT = 7;

   // Opcode patterns: upper bits for copy and store, whole word for configuration load, masked word for no-operation
   localparam logic [5:0] OPC_COPY_HI  = 6'h08;
   localparam logic [6:0] OPC_STORE_HI = 7'h01;
   localparam logic [13:0] OPC_CFG_LOAD = 14'h0062;
   localparam logic [13:0] NOP_MASK     = 14'h3f9f;
   localparam logic [13:0] NOP_VALUE    = 14'h0000;

   // Address of the configuration register in the data file
   localparam logic [6:0] CFG_ADDR  = 7'h01;
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE     = 3'b000,
      OP_COPY     = 3'b001,
      OP_STORE    = 3'b010,
      OP_CFG_LOAD = 3'b011,
      OP_NOP      = 3'b100
   } op_e;

   typedef struct packed {
      logic             valid;
      logic [13:0]      word;
   } instr_s;

   typedef struct packed {
      logic             we;
      logic [6:0]       addr;
      logic [7:0]       data;
   } file_wr_s;

endpackage

// [data_file_mem.sv]
// Data file memory: synchronous write, registered read; the configuration register is held outside it
`timescale 1ns/1ps
module data_file_mem
   import move_decode_pkg::*;
#(
   parameter int DEPTH = 128
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data
);

   logic [DATA_W-1:0] mem [DEPTH];

   // Storage left unreset: it models ordinary RAM
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= DATA_ZERO;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// [move_and_config_instr_decode.sv]
// Decoder and executor for the copy, store, no-operation and configuration-load instructions
`timescale 1ns/1ps
module move_and_config_instr_decode
   import move_decode_pkg::*;
#(
   parameter int FILE_DEPTH = 128
) (
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire instr_s            instr,
   output logic      [DATA_W-1:0] acc,
   output logic                   zero_flag,
   output logic      [DATA_W-1:0] cfg_reg,
   output logic                   busy,
   output logic                   done
);

   // ==========================================================
   // Reset release
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ==========================================================
   // Decode
   op_e               op_nxt;
   logic [ADDR_W-1:0] fld_addr;
   logic              fld_dir;

   assign fld_addr = instr.word[ADDR_W-1:0];
   assign fld_dir  = instr.word[DIR_BIT];

   always_comb begin
      op_nxt = OP_NONE;
      if (instr.valid) begin
         if (instr.word[INSTR_W-1 -: $bits(OPC_COPY_HI)] == OPC_COPY_HI) begin
            op_nxt = OP_COPY;
         end else if (instr.word[INSTR_W-1 -: $bits(OPC_STORE_HI)] == OPC_STORE_HI) begin
            op_nxt = OP_STORE;
         end else if (instr.word == OPC_CFG_LOAD) begin
            op_nxt = OP_CFG_LOAD;
         end else if ((instr.word & NOP_MASK) == NOP_VALUE) begin
            op_nxt = OP_NOP;
         end
      end
   end

   // ==========================================================
   // Execute: copy reads in cycle one, commits in cycle two
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01
   } state_e;

   state_e            state_r;
   logic              dir_r;
   logic [ADDR_W-1:0] addr_r;

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
         dir_r   <= 1'b0;
         addr_r  <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (op_nxt == OP_COPY) begin
                  state_r <= ST_READ;
                  dir_r   <= fld_dir;
                  addr_r  <= fld_addr;
               end
            end
            ST_READ: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   logic              idle;
   logic              in_read;
   logic [DATA_W-1:0] mem_rd;
   logic [DATA_W-1:0] moved;
   file_wr_s          wr;

   assign idle    = (state_r == ST_IDLE);
   assign in_read = (state_r == ST_READ);

   // Configuration register lives outside the memory, so reads of its address bypass it
   assign moved = (addr_r == CFG_ADDR) ? cfg_reg : mem_rd;

   always_comb begin
      wr = '0;
      if (in_read && dir_r) begin
         wr = '{we: 1'b1, addr: addr_r, data: moved};
      end else if (idle && op_nxt == OP_STORE) begin
         wr = '{we: 1'b1, addr: fld_addr, data: acc};
      end
   end

   data_file_mem #(
      .DEPTH (FILE_DEPTH)
   ) u_mem (
      .sys_clk (sys_clk),
      .rst_n   (rst_n_r),
      .wr_en   (wr.we && wr.addr != CFG_ADDR),
      .wr_addr (wr.addr),
      .wr_data (wr.data),
      .rd_addr (fld_addr),
      .rd_data (mem_rd)
   );

   // ==========================================================
   // Architectural state
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         acc <= DATA_ZERO;
      end else if (in_read && !dir_r) begin
         acc <= moved;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         zero_flag <= 1'b0;
      end else if (in_read) begin
         zero_flag <= (moved == DATA_ZERO);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         cfg_reg <= CFG_RESET;
      end else if (idle && op_nxt == OP_CFG_LOAD) begin
         cfg_reg <= acc;
      end else if (wr.we && wr.addr == CFG_ADDR) begin
         cfg_reg <= wr.data;
      end
   end

   // Busy flags the cycle in which a copy commits; an instruction presented in that cycle is dropped
   always_ff @(posedge sys_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         busy <= idle && op_nxt == OP_COPY;
         done <= in_read || (idle && (op_nxt == OP_STORE || op_nxt == OP_CFG_LOAD || op_nxt == OP_NOP));
      end
   end

   // ==========================================================
   // Checks
   a_copy_to_acc: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      in_read && !dir_r |=> acc == $past(moved))
      else $error("copy did not load accumulator");
   a_copy_zero: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      in_read |=> zero_flag == ($past(moved) == DATA_ZERO))
      else $error("zero flag wrong after copy");
   a_store_flags: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      idle && op_nxt == OP_STORE |=> $stable(zero_flag) && $stable(acc))
      else $error("store changed flags or accumulator");
   a_cfg_load: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      idle && op_nxt == OP_CFG_LOAD |=> cfg_reg == $past(acc) && $stable(zero_flag))
      else $error("configuration load failed");
   a_cfg_mapped: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      idle && op_nxt == OP_STORE && fld_addr == CFG_ADDR |=> cfg_reg == $past(acc))
      else $error("configuration not written as file register");
   a_nop_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      idle && op_nxt == OP_NOP |=> $stable(acc) && $stable(zero_flag) && $stable(cfg_reg) && done)
      else $error("no-operation changed state");
   a_copy_two: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      idle && op_nxt == OP_COPY |=> busy ##1 done && !busy)
      else $error("copy timing wrong");
   a_copy_back: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
      in_read && dir_r |=> $stable(acc))
      else $error("write-back copy touched accumulator");

   c_copy_w: cover property (@(posedge sys_clk) in_read && !dir_r);
   c_copy_f: cover property (@(posedge sys_clk) in_read && dir_r && moved == DATA_ZERO);
   c_cfg: cover property (@(posedge sys_clk) idle && op_nxt == OP_CFG_LOAD);
   c_store_cfg: cover property (@(posedge sys_clk) idle && op_nxt == OP_STORE && fld_addr == CFG_ADDR);

endmodule

// [move_and_config_instr_decode_bench.sv]
// Self-checking bench for the move and configuration instruction decoder
`timescale 1ns/1ps
module move_and_config_instr_decode_bench
   import move_decode_pkg::*;
();
   typedef struct packed {
      logic [13:0] word;
      logic [1:0]  lat;
      logic [7:0]  acc;
      logic        z;
      logic [7:0]  cfg;
   } row_s;

   logic              sys_clk = 1'b0;
   logic              reset_n;
   instr_s            instr;
   logic [DATA_W-1:0] acc;
   logic              zero_flag;
   logic [DATA_W-1:0] cfg_reg;
   logic              busy;
   logic              done;
   int                num_errors;
   int                n_tests;
   row_s              rows [17];

   move_and_config_instr_decode #(.FILE_DEPTH(128)) i_dut (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .instr     (instr),
      .acc       (acc),
      .zero_flag (zero_flag),
      .cfg_reg   (cfg_reg),
      .busy      (busy),
      .done      (done)
   );

   always #4 sys_clk = ~sys_clk;

   // ==========================================
   // Compare and drive tasks
   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk1(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Latency 0 means the word must be refused
   task automatic issue(input logic [13:0] w, input int lat);
      @(posedge sys_clk);
      #1 instr = '{valid: 1'b1, word: w};
      @(posedge sys_clk);
      #1 instr.valid = 1'b0;
      if (lat == 2) begin
         chk1("busy", 1'b1, busy);
         chk1("done early", 1'b0, done);
         @(posedge sys_clk);
         #1;
      end
      chk1("done", lat != 0, done);
   endtask

   task automatic chk_state(input logic [7:0] a, input logic z, input logic [7:0] c);
      chk8("acc", a, acc);
      chk1("zero_flag", z, zero_flag);
      chk8("cfg_reg", c, cfg_reg);
   endtask

   // ==========================================
   // Watchdog
   initial begin
      #(8 * 2000);
      num_errors++;
      report_and_stop();
   end

   // ==========================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      instr = '0;
      rows = '{
         '{14'h0090, 2'd1, 8'h00, 1'b0, 8'hff}, '{14'h0801, 2'd2, 8'hff, 1'b0, 8'hff},
         '{14'h00a0, 2'd1, 8'hff, 1'b0, 8'hff}, '{14'h0810, 2'd2, 8'h00, 1'b1, 8'hff},
         '{14'h0081, 2'd1, 8'h00, 1'b1, 8'h00}, '{14'h0820, 2'd2, 8'hff, 1'b0, 8'h00},
         '{14'h0062, 2'd1, 8'hff, 1'b0, 8'hff}, '{14'h0890, 2'd2, 8'hff, 1'b1, 8'hff},
         '{14'h0810, 2'd2, 8'h00, 1'b1, 8'hff}, '{14'h08a0, 2'd2, 8'h00, 1'b0, 8'hff},
         '{14'h0000, 2'd1, 8'h00, 1'b0, 8'hff}, '{14'h0020, 2'd1, 8'h00, 1'b0, 8'hff},
         '{14'h0040, 2'd1, 8'h00, 1'b0, 8'hff}, '{14'h0060, 2'd1, 8'h00, 1'b0, 8'hff},
         '{14'h0001, 2'd0, 8'h00, 1'b0, 8'hff}, '{14'h3fff, 2'd0, 8'h00, 1'b0, 8'hff},
         '{14'h0820, 2'd2, 8'hff, 1'b0, 8'hff}};
      repeat (16) @(posedge sys_clk);
      #1 chk_state(8'h00, 1'b0, 8'hff);
      chk1("busy", 1'b0, busy);
      reset_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      foreach (rows[i]) begin
         issue(rows[i].word, int'(rows[i].lat));
         chk_state(rows[i].acc, rows[i].z, rows[i].cfg);
      end
      // Back-to-back stores, no idle cycle between them
      @(posedge sys_clk);
      #1 instr = '{valid: 1'b1, word: 14'h00b0};
      @(posedge sys_clk);
      #1 instr.word = 14'h00b1;
      chk1("done", 1'b1, done);
      @(posedge sys_clk);
      #1 instr.valid = 1'b0;
      chk1("done", 1'b1, done);
      issue(14'h0810, 2);
      issue(14'h0831, 2);
      chk_state(8'hff, 1'b0, 8'hff);
      // A load presented in the busy cycle must be dropped
      issue(14'h0810, 2);
      @(posedge sys_clk);
      #1 instr = '{valid: 1'b1, word: 14'h0830};
      @(posedge sys_clk);
      #1 instr.word = 14'h0062;
      @(posedge sys_clk);
      #1 instr.valid = 1'b0;
      chk1("done", 1'b1, done);
      repeat (2) @(posedge sys_clk);
      #1 chk_state(8'hff, 1'b0, 8'hff);
      // Reset in mid-run, taken without a clock edge
      reset_n = 1'b0;
      #1 chk_state(8'h00, 1'b0, 8'hff);
      repeat (4) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      issue(14'h0801, 2);
      chk_state(8'hff, 1'b0, 8'hff);
      // Configuration set and tested through ordinary file accesses only
      issue(14'h0810, 2);
      issue(14'h0081, 1);
      chk_state(8'h00, 1'b1, 8'h00);
      issue(14'h0820, 2);
      issue(14'h0881, 2);
      chk_state(8'hff, 1'b1, 8'h00);
      report_and_stop();
   end
endmodule
